// ---- rtl/cpusf_defines.vh ----
// Purpose: constants for the processor flags and reset-cause register
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses
`ifndef CPUSF_DEFINES_VH
`define CPUSF_DEFINES_VH
`define CPUSF_OFF_FLAGS   4'h0
`define CPUSF_OFF_OP      4'h4
`define CPUSF_OFF_RESULT  4'h8
`define CPUSF_BIT_TIMEOUT 4
`define CPUSF_BIT_PWRDN   3
`define CPUSF_BIT_ZERO    2
`define CPUSF_BIT_NIBBLE  1
`define CPUSF_BIT_CARRY   0
`define CPUSF_RST_FLAGS   5'h18
// Operation codes written to the command register
`define CPUSF_OP_NONE     4'h0
`define CPUSF_OP_ADD      4'h1
`define CPUSF_OP_SUB      4'h2
`define CPUSF_OP_LOGIC    4'h3
`define CPUSF_OP_CLEAR       4'h4
`define CPUSF_OP_MOVE        4'h5
`define CPUSF_OP_WDOG_CLEAR  4'h6
`define CPUSF_OP_SLEEP       4'h7
`define CPUSF_OP_WDOG_EXPIRE 4'h8
`define CPUSF_RESP_OKAY   2'h0
`define CPUSF_RESP_SLVERR 2'h2
`endif

// ---- rtl/cpusf_status_flags.v ----
// Purpose: processor status register with ALU flags and reset-cause flags
// Assumes: one clock; operations issued by writes to a command register
// Notes:   command word = {file_to_status[12], op[11:8], operand_a[7:0]};
//          operand b is held in the result register (offset 8)
// Notes on behaviour
// [RULE1] Clear-file on status clears upper bits, sets zero flag.
// [RULE2] Software should alter status only with flag-neutral instructions.
// [RULE3] Bits 7 to 5 are unimplemented and read zero.
// [RULE4] Timeout flag set at power-up, watchdog clear, or sleep.
// [RULE5] Timeout flag cleared on watchdog timer time-out.
// [RULE6] Nibble carry flag reflects carry out of bit 3.
// [RULE7] Carry flag reflects carry out of the top bit.
// [RULE8] Add and subtract operations update carry and nibble carry.
// [RULE9] On subtraction a one means no borrow.
// [RULE10] Subtraction adds the two's complement of the second operand.
// [RULE11] Power-down flag set at power-up or watchdog clear, cleared by sleep.
// [RULE12] Zero flag follows whether an arithmetic or logic result is zero.
// [RULE13] Flag-writing instructions targeting status keep flag logic values.
// [RULE14] Timeout and power-down flags ignore register writes.
`timescale 1ns/1ns
`include "cpusf_defines.vh"
module cpusf_status_flags (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite write
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Flag outputs
  output reg  [4:0]  status_q
);
  reg        aw_held_q;
  reg [3:0]  awaddr_q;
  reg        w_held_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg [7:0]  result_q;
  reg [3:0]  last_op_q;
  reg [4:0]  status_d;
  reg [7:0]  result_d;
  reg        wr_ok;

  wire       do_wr    = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire       op_wr    = do_wr & (awaddr_q == `CPUSF_OFF_OP) & wstrb_q[0] & wstrb_q[1];
  wire [3:0] op       = wdata_q[11:8];
  wire       to_file  = wdata_q[12];
  wire [7:0] opa      = wdata_q[7:0];
  wire       is_sub   = (op == `CPUSF_OP_SUB);
  // [RULE10] Two's complement add
  wire [7:0] opb      = is_sub ? ~result_q : result_q;
  // Plus one as carry-in, not folded into b: folding loses
  // the nibble carry whenever the low nibble of b is zero
  wire [8:0] sum      = {1'b0, opa} + {1'b0, opb} + {8'h00, is_sub};
  wire [4:0] nib      = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
  wire       carry    = sum[8];
  wire       nibc     = nib[4];
  wire [7:0] logic_r  = opa & result_q;

  always @* begin
    status_d = status_q;
    result_d = result_q;
    wr_ok    = 1'b1;
    if (do_wr) begin
      case (awaddr_q)
        `CPUSF_OFF_FLAGS: begin
          // [RULE14] Only low three bits writable
          if (wstrb_q[0])
            status_d[2:0] = wdata_q[2:0];
        end
        `CPUSF_OFF_RESULT: begin
          if (wstrb_q[0])
            result_d = wdata_q[7:0];
        end
        `CPUSF_OFF_OP: begin
          if (op_wr) begin
            case (op)
              `CPUSF_OP_ADD, `CPUSF_OP_SUB: begin
                // [RULE8] Arithmetic flag update
                result_d = sum[7:0];
                // [RULE6] [RULE9] Nibble carry
                status_d[`CPUSF_BIT_NIBBLE] = nibc;
                // [RULE7] [RULE9] Top carry
                status_d[`CPUSF_BIT_CARRY]  = carry;
                // [RULE12] Zero detect
                status_d[`CPUSF_BIT_ZERO]   = (sum[7:0] == 8'h00);
                // [RULE13] File write to status blocked
              end
              `CPUSF_OP_LOGIC: begin
                result_d = logic_r;
                // [RULE12] Zero detect
                status_d[`CPUSF_BIT_ZERO] = (logic_r == 8'h00);
                // [RULE13] Carries not written
                // Destination status leaves them as they were;
                // only the zero flag follows the flag logic
              end
              `CPUSF_OP_CLEAR: begin
                // [RULE1] Clear-file on status
                result_d = 8'h00;
                status_d[`CPUSF_BIT_ZERO] = 1'b1;
              end
              `CPUSF_OP_MOVE: begin
                result_d = opa;
                if (to_file)
                  status_d[2:0] = opa[2:0];
              end
              `CPUSF_OP_WDOG_CLEAR: begin
                // [RULE4] [RULE11] Watchdog clear
                status_d[`CPUSF_BIT_TIMEOUT] = 1'b1;
                status_d[`CPUSF_BIT_PWRDN]   = 1'b1;
              end
              `CPUSF_OP_SLEEP: begin
                // [RULE4] [RULE11] Sleep
                status_d[`CPUSF_BIT_TIMEOUT] = 1'b1;
                status_d[`CPUSF_BIT_PWRDN]   = 1'b0;
              end
              `CPUSF_OP_WDOG_EXPIRE: begin
                // [RULE5] Watchdog time-out
                status_d[`CPUSF_BIT_TIMEOUT] = 1'b0;
              end
              `CPUSF_OP_NONE: begin
                result_d = result_q;
              end
              default: begin
                wr_ok = 1'b0;
              end
            endcase
          end
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CPUSF_RESP_OKAY;
      // [RULE4] [RULE11] Power-up values
      status_q      <= `CPUSF_RST_FLAGS;
      result_q      <= 8'h00;
      last_op_q     <= `CPUSF_OP_NONE;
    end else begin
      status_q      <= status_d;
      result_q      <= result_d;
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `CPUSF_RESP_OKAY : `CPUSF_RESP_SLVERR;
        if (op_wr)
          last_op_q <= op;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; one cycle from address to data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CPUSF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CPUSF_RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
          // [RULE3] Upper bits read zero
          `CPUSF_OFF_FLAGS:  s_axi_rdata <= {27'h0, status_q};
          `CPUSF_OFF_OP:     s_axi_rdata <= {28'h0, last_op_q};
          `CPUSF_OFF_RESULT: s_axi_rdata <= {24'h0, result_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CPUSF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- testbench/cpusf_asserts.sv ----
// Purpose: bus and flag checks for the status block
// Assumes: one clock, rst_n async active low
// Notes:   read address kept to judge read data
`timescale 1ns/1ns
module cpusf_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Flags
  input wire logic [4:0]  status_q
);
  logic [3:0] ra_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ra_q <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken; s_axi_awready && s_axi_wready; endsequence
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  AST_BANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_RANSWER: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read not answered");
  AST_UPPER_ZERO: assert property (
    s_axi_rvalid && ra_q == 4'h0 |-> s_axi_rdata == {27'h0, status_q})
    else $error("status read wrong");
  // Decode ignores the two low address bits
  AST_UNMAPPED: assert property (s_axi_rvalid && ra_q[3:2] == 2'b11
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  AST_QUIET: assert property (!$stable(status_q) |-> $rose(s_axi_bvalid))
    else $error("flags moved without a write");
  AST_SLEEP: assert property ($fell(status_q[3]) |-> status_q[4])
    else $error("sleep left timeout clear");
  AST_TIMEOUT: assert property ($fell(status_q[4]) |-> $stable(status_q[3:0]))
    else $error("timeout touched other flags");
  AST_WAKE: assert property ($rose(status_q[3]) |-> status_q[4])
    else $error("power-down set without timeout");
endmodule
bind cpusf_status_flags cpusf_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .status_q(status_q));

// ---- testbench/test_cpu_status_flags.sv ----
// Purpose: self-checking bench for the status block
// Assumes: bready and rready held high, full strobes
// Notes:   expected flags built from a 9-bit sum and a 5-bit nibble sum
`timescale 1ns/1ns
`include "cpusf_defines.vh"
module test_cpu_status_flags;
  logic clk, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0;
  wire awr, wrd, bv, arr, rv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [4:0] sq;
  int checked = 0, mismatches = 0;
  cpusf_status_flags DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .status_q(sq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    r = br;
    if (n == 40) begin
      mismatches++;
      report_and_stop;
    end
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdat;
    r = rr;
    if (n == 40) begin
      mismatches++;
      report_and_stop;
    end
  endtask
  task automatic op(input logic [3:0] c, input logic s, input logic [7:0] a);
    logic [1:0] r;
    bus_wr(4'h4, {19'h0, s, c, a}, r);
    chk("op resp", 32'h0, r);
  endtask
  // Flags {zero, nibble carry, carry} and result; subtraction adds ~b plus one
  function automatic logic [10:0] fl(input logic s, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] m;
    logic [8:0] t;
    logic [4:0] h;
    m = s ? ~b : b;
    t = {1'b0, a} + {1'b0, m} + {8'h0, s};
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, s};
    fl = {t[7:0] == 8'h00, h[4], t[8], t[7:0]};
  endfunction
  task automatic t_arith;
    logic [17:0] tb [9] = '{18'h00f01, 18'h0f010, 18'h0ffff, 18'h20505, 18'h21001,
                            18'h20102, 18'h20510, 18'h33300, 18'h1f0e0};
    logic [10:0] e;
    logic [31:0] d;
    logic [1:0]  r;
    chk("reset flags", 5'h18, sq);
    bus_rd(4'h0, d, r);
    chk("reset read", 32'h18, d);
    foreach (tb[i]) begin
      e = fl(tb[i][17], tb[i][15:8], tb[i][7:0]);
      bus_wr(4'h8, {24'h0, tb[i][7:0]}, r);
      op(tb[i][17] ? `CPUSF_OP_SUB : `CPUSF_OP_ADD, tb[i][16], tb[i][15:8]);
      chk("flags", {2'b11, e[10:8]}, sq);
      bus_rd(4'h8, d, r);
      if (!tb[i][16]) chk("result", e[7:0], d);
    end
    bus_wr(4'h8, 32'hf0, r);
    op(`CPUSF_OP_LOGIC, 1'b0, 8'h0f);
    chk("and zero", 5'h1d, sq);
    op(`CPUSF_OP_LOGIC, 1'b1, 8'h0f);
    chk("and to status", 5'h1d, sq);
    $display("arith done");
  endtask
  task automatic t_cause;
    logic [31:0] d;
    logic [1:0]  r;
    op(`CPUSF_OP_SLEEP, 1'b0, 8'h0);
    chk("sleep", 2'b10, sq[4:3]);
    op(`CPUSF_OP_WDOG_EXPIRE, 1'b0, 8'h0);
    chk("timeout", 5'h05, sq);
    bus_wr(4'h0, 32'hff, r);
    chk("write", 5'h07, sq);
    bus_rd(4'h0, d, r);
    chk("read", 32'h07, d);
    bus_wr(4'h0, 32'hfa, r);
    op(`CPUSF_OP_CLEAR, 1'b0, 8'h0);
    chk("clear", 5'h06, sq);
    op(`CPUSF_OP_WDOG_CLEAR, 1'b0, 8'h0);
    chk("wdt clear", 5'h1e, sq);
    op(`CPUSF_OP_MOVE, 1'b1, 8'h05);
    chk("move", 5'h1d, sq);
    bus_rd(4'h4, d, r);
    chk("last op", `CPUSF_OP_MOVE, d);
    op(`CPUSF_OP_NONE, 1'b0, 8'h0);
    chk("no op", 5'h1d, sq);
    bus_rd(4'hc, d, r);
    chk("unmapped", 32'h2, {d[29:0], r});
    bus_wr(4'h4, 32'h900, r);
    chk("bad op", 32'h2, r);
    $display("cause done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_arith;
    t_cause;
    report_and_stop;
  end
endmodule
